// >>> fpg_pkg.sv
// Package for the four pin configuration port: register map, fields, resets
package fpg_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [6:0] FPG_IDX_PIN1_CONFIG        = 7'h58;
    localparam logic [6:0] FPG_IDX_PIN2_CONFIG        = 7'h59;
    localparam logic [6:0] FPG_IDX_PIN3_CONFIG        = 7'h5A;
    localparam logic [6:0] FPG_IDX_PIN4_CONFIG        = 7'h5B;
    localparam logic [6:0] FPG_IDX_PIN_INPUT_READBACK = 7'h5C;

    // ----------------------------------------------------------------
    // Bus and port widths
    // ----------------------------------------------------------------
    localparam int FPG_ADR_W  = 9;
    localparam int FPG_DAT_W  = 32;
    localparam int FPG_SEL_W  = 4;
    localparam int FPG_PINS   = 4;

    // ----------------------------------------------------------------
    // Pin configuration field positions
    // ----------------------------------------------------------------
    localparam int FPG_CFG_CMP_EN_POS   = 4;
    localparam int FPG_CFG_LINK_POS     = 3;
    localparam int FPG_CFG_DIR_IN_POS   = 2;
    localparam int FPG_CFG_PULL_UP_POS  = 1;
    localparam int FPG_CFG_OD_LOW_POS   = 0;

    // Read-back field positions
    localparam int FPG_RDB_LEVEL_LSB    = 4;
    localparam int FPG_RDB_THRESH_POS   = 0;

    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic pin_comparator_enable;
        logic pin_link_control_select;
        logic pin_direction_input;
        logic pin_pull_select;
        logic pin_open_drain_level;
    } fpg_cfg_s;

    typedef struct packed {
        logic [FPG_PINS-1:0] pin_input_level;
        logic                input_threshold_select;
    } fpg_rdb_s;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam fpg_cfg_s FPG_CFG_RESET = '{
        pin_comparator_enable:   1'b1,
        pin_link_control_select: 1'b1,
        pin_direction_input:     1'b0,
        pin_pull_select:         1'b0,
        pin_open_drain_level:    1'b0
    };
    localparam logic [FPG_PINS-1:0] FPG_LEVEL_RESET  = 4'h0;
    localparam logic                FPG_THRESH_RESET = 1'b0;

endpackage : fpg_pkg

// >>> fpg_top.sv
// Four pin configuration port with a classic Wishbone register slave
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns

module fpg_top (
    // Clock, reset, enable
    input  wire logic                           i_clk,
    input  wire logic                           i_rst_n,
    input  wire logic                           i_ce,
    // Wishbone classic slave
    input  wire logic                           i_wb_cyc,
    input  wire logic                           i_wb_stb,
    input  wire logic                           i_wb_we,
    input  wire logic [fpg_pkg::FPG_ADR_W-1:0]  i_wb_adr,
    input  wire logic [fpg_pkg::FPG_SEL_W-1:0]  i_wb_sel,
    input  wire logic [fpg_pkg::FPG_DAT_W-1:0]  i_wb_dat,
    output logic      [fpg_pkg::FPG_DAT_W-1:0]  o_wb_dat,
    output logic                                o_wb_ack,
    // Power-line link pin commands
    input  wire logic [fpg_pkg::FPG_PINS-1:0]   i_link_pull_low,
    // Pins
    input  wire logic [fpg_pkg::FPG_PINS-1:0]   i_pin_i,
    output logic      [fpg_pkg::FPG_PINS-1:0]   o_pin_o,
    output logic      [fpg_pkg::FPG_PINS-1:0]   o_pin_oe,
    output logic      [fpg_pkg::FPG_PINS-1:0]   o_pull_up_en,
    output logic      [fpg_pkg::FPG_PINS-1:0]   o_pull_down_en,
    output logic      [fpg_pkg::FPG_PINS-1:0]   o_cmp_en,
    output logic                                o_threshold_sel
);
    import fpg_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Pin number 0..3 of a config index, or 4 when not a config register
    function automatic logic [2:0] cfg_pin(input logic [6:0] idx);
        logic [2:0] p;
        p = 3'h4;
        if (idx == FPG_IDX_PIN1_CONFIG) begin
            p = 3'h0;
        end else if (idx == FPG_IDX_PIN2_CONFIG) begin
            p = 3'h1;
        end else if (idx == FPG_IDX_PIN3_CONFIG) begin
            p = 3'h2;
        end else if (idx == FPG_IDX_PIN4_CONFIG) begin
            p = 3'h3;
        end
        return p;
    endfunction : cfg_pin

    function automatic logic [FPG_DAT_W-1:0] cfg_word(input fpg_cfg_s c);
        return {27'h0000000, c};
    endfunction : cfg_word

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    fpg_cfg_s                 cfg_q [FPG_PINS];
    logic [FPG_PINS-1:0]      level_q;
    logic                     thresh_q;
    logic                     req;
    logic                     wr_stb;
    logic                     rd_stb;
    logic [6:0]               idx;
    logic                     aligned;
    logic [2:0]               pin_sel;

    assign req     = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign idx     = i_wb_adr[8:2];
    assign aligned = (i_wb_adr[1:0] == 2'h0);
    assign pin_sel = cfg_pin(idx);
    assign wr_stb  = req && i_wb_we && aligned && i_wb_sel[0];
    assign rd_stb  = req && !i_wb_we;

    // ----------------------------------------------------------------
    // Acknowledge: one cycle after the request, every address
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
        end else if (i_ce) begin
            o_wb_ack <= req;
        end
    end

    // ----------------------------------------------------------------
    // Read data; unmapped addresses read zero
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_wb_dat <= 32'h00000000;
        end else if (i_ce && rd_stb) begin
            if (!aligned) begin
                o_wb_dat <= 32'h00000000;
            end else if (pin_sel != 3'h4) begin
                o_wb_dat <= cfg_word(cfg_q[pin_sel[1:0]]);
            end else if (idx == FPG_IDX_PIN_INPUT_READBACK) begin
                o_wb_dat <= {24'h000000, level_q, 3'h0, thresh_q};
            end else begin
                o_wb_dat <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < FPG_PINS; i++) begin
                cfg_q[i] <= FPG_CFG_RESET;
            end
        end else if (i_ce && wr_stb && pin_sel != 3'h4) begin
            cfg_q[pin_sel[1:0]] <= fpg_cfg_s'(i_wb_dat[4:0]);
        end
    end

    // ----------------------------------------------------------------
    // Threshold select
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            thresh_q <= FPG_THRESH_RESET;
        end else if (i_ce && wr_stb && idx == FPG_IDX_PIN_INPUT_READBACK) begin
            thresh_q <= i_wb_dat[FPG_RDB_THRESH_POS];
        end
    end

    // ----------------------------------------------------------------
    // Input levels, held at zero while the comparator is off
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            level_q <= FPG_LEVEL_RESET;
        end else if (i_ce) begin
            for (int i = 0; i < FPG_PINS; i++) begin
                level_q[i] <= cfg_q[i].pin_comparator_enable && i_pin_i[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pin_o        <= 4'h0;
            o_pin_oe       <= 4'h0;
            o_pull_up_en   <= 4'h0;
            o_pull_down_en <= 4'h0;
            o_cmp_en       <= 4'hF;
            o_threshold_sel <= FPG_THRESH_RESET;
        end else if (i_ce) begin
            o_pin_o         <= 4'h0;
            o_threshold_sel <= thresh_q;
            for (int i = 0; i < FPG_PINS; i++) begin
                o_cmp_en[i] <= cfg_q[i].pin_comparator_enable;
                // Pulls only when the pin is an input
                o_pull_up_en[i]   <= cfg_q[i].pin_direction_input &&
                                     cfg_q[i].pin_pull_select;
                o_pull_down_en[i] <= cfg_q[i].pin_direction_input &&
                                     !cfg_q[i].pin_pull_select;
                if (cfg_q[i].pin_direction_input) begin
                    o_pin_oe[i] <= 1'b0;
                end else if (cfg_q[i].pin_link_control_select) begin
                    o_pin_oe[i] <= i_link_pull_low[i];
                end else begin
                    o_pin_oe[i] <= cfg_q[i].pin_open_drain_level;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Reset in antecedents: no attempt from the last reset edge
    property p_cfg_reset_cmp;
        @(posedge i_clk) $rose(i_rst_n) |->
            (cfg_q[0].pin_comparator_enable && cfg_q[3].pin_comparator_enable &&
             o_cmp_en == 4'hF);
    endproperty
    a_cfg_reset_cmp: assert property (p_cfg_reset_cmp)
        else $error("comparator enable not set after reset");

    property p_cfg_reset_link;
        @(posedge i_clk) $rose(i_rst_n) |->
            (cfg_q[0].pin_link_control_select && cfg_q[1].pin_link_control_select &&
             cfg_q[2].pin_link_control_select && cfg_q[3].pin_link_control_select);
    endproperty
    a_cfg_reset_link: assert property (p_cfg_reset_link)
        else $error("link control not selected after reset");

    property p_rdb_reset;
        @(posedge i_clk) $rose(i_rst_n) |-> (level_q == 4'h0 && !thresh_q &&
            !cfg_q[0].pin_direction_input && o_pin_oe == 4'h0);
    endproperty
    a_rdb_reset: assert property (p_rdb_reset)
        else $error("read-back or direction not cleared by reset");

    for (genvar g = 0; g < FPG_PINS; g++) begin : g_pin_chk
        property p_input_no_drive;
            @(posedge i_clk) disable iff (!i_rst_n)
                (i_rst_n && i_ce && cfg_q[g].pin_direction_input) |=> !o_pin_oe[g];
        endproperty
        a_input_no_drive: assert property (p_input_no_drive)
            else $error("input pin is driven");

        property p_pull_only_input;
            @(posedge i_clk) disable iff (!i_rst_n)
                (i_rst_n && i_ce) |=> ((o_pull_up_en[g] || o_pull_down_en[g]) ==
                          $past(cfg_q[g].pin_direction_input)) &&
                         (o_pull_up_en[g] == ($past(cfg_q[g].pin_direction_input) &&
                          $past(cfg_q[g].pin_pull_select)));
        endproperty
        a_pull_only_input: assert property (p_pull_only_input)
            else $error("pull resistor wrong for pin configuration");

        property p_local_od;
            @(posedge i_clk) disable iff (!i_rst_n)
                (i_rst_n && i_ce && !cfg_q[g].pin_direction_input &&
                 !cfg_q[g].pin_link_control_select) |=>
                (o_pin_oe[g] == $past(cfg_q[g].pin_open_drain_level)) && !o_pin_o[g];
        endproperty
        a_local_od: assert property (p_local_od)
            else $error("local open-drain output wrong");

        property p_link_od;
            @(posedge i_clk) disable iff (!i_rst_n)
                (i_rst_n && i_ce && !cfg_q[g].pin_direction_input &&
                 cfg_q[g].pin_link_control_select) |=>
                o_pin_oe[g] == $past(i_link_pull_low[g]);
        endproperty
        a_link_od: assert property (p_link_od)
            else $error("link-controlled output does not follow link");

        property p_level_sample;
            @(posedge i_clk) disable iff (!i_rst_n)
                (i_rst_n && i_ce) |=> level_q[g] == ($past(i_pin_i[g]) &&
                                        $past(cfg_q[g].pin_comparator_enable));
        endproperty
        a_level_sample: assert property (p_level_sample)
            else $error("input level read-back wrong");

        property p_cfg_write;
            @(posedge i_clk) disable iff (!i_rst_n)
                (i_rst_n && i_ce && wr_stb && pin_sel == 3'(g)) |=>
                cfg_q[g] == fpg_cfg_s'($past(i_wb_dat[4:0]));
        endproperty
        a_cfg_write: assert property (p_cfg_write)
            else $error("config write not applied");
    end

    property p_thresh_write;
        @(posedge i_clk) disable iff (!i_rst_n)
            (i_ce && wr_stb && idx == FPG_IDX_PIN_INPUT_READBACK) ##1 i_ce |=>
            o_threshold_sel == $past(i_wb_dat[0], 2);
    endproperty
    a_thresh_write: assert property (p_thresh_write)
        else $error("threshold select write not applied");

    property p_ack_one;
        @(posedge i_clk) disable iff (!i_rst_n)
            (i_rst_n && i_ce && req) |=> o_wb_ack ##1 (!o_wb_ack || !i_ce);
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack not a single cycle after request");

    property p_rdb_read;
        @(posedge i_clk) disable iff (!i_rst_n)
            (i_rst_n && i_ce && rd_stb && aligned && idx == FPG_IDX_PIN_INPUT_READBACK) |=>
            (o_wb_dat == {24'h000000, $past(level_q), 3'h0, $past(thresh_q)});
    endproperty
    a_rdb_read: assert property (p_rdb_read)
        else $error("read-back word wrong");

    property p_ce_freeze;
        @(posedge i_clk) disable iff (!i_rst_n)
            (i_rst_n && !i_ce) |=> $stable(o_pin_oe) && $stable(level_q) &&
                                   $stable(thresh_q) && $stable(cfg_q[0]);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state moved while clock enable low");

    c_cfg_write: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && wr_stb && pin_sel != 3'h4);
    c_link_drive: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pin_oe[0] && cfg_q[0].pin_link_control_select);
    c_rdb_read: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && rd_stb && idx == FPG_IDX_PIN_INPUT_READBACK && level_q != 4'h0);
    c_ce_freeze: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_ce && o_pin_oe != 4'h0);
    c_pull_up: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pull_up_en != 4'h0);

endmodule : fpg_top

// >>> fpg_pin_model.sv
// Far-side model: pin wiring with external pull-up and an outside driver
`timescale 1ns/1ns
module fpg_pin_model (
    // Device pin side
    input  wire logic [3:0] i_pin_oe,
    input  wire logic [3:0] i_pin_o,
    input  wire logic [3:0] i_pull_down_en,
    // Outside driver of the pins
    input  wire logic [3:0] i_ext_en,
    input  wire logic [3:0] i_ext_val,
    // Resolved pin level
    output logic      [3:0] o_pin_lvl
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (i_pin_oe[i]) begin
                o_pin_lvl[i] = i_pin_o[i];
            end else if (i_ext_en[i]) begin
                o_pin_lvl[i] = i_ext_val[i];
            end else begin
                // Released line: pull-down if enabled, else external pull-up
                o_pin_lvl[i] = ~i_pull_down_en[i];
            end
        end
    end
endmodule : fpg_pin_model

// >>> tb_four_pin_gpio_config_port.sv
// Self-checking testbench for the four pin configuration port
`timescale 1ns/1ns
module tb_four_pin_gpio_config_port;
    import fpg_pkg::*;
    logic                 i_clk   = 1'b0;
    logic                 i_rst_n = 1'b0;
    logic                 cyc     = 1'b0;
    logic                 stb     = 1'b0;
    logic                 we      = 1'b0;
    logic [FPG_ADR_W-1:0] adr     = '0;
    logic [FPG_SEL_W-1:0] sel     = '0;
    logic [FPG_DAT_W-1:0] wdat    = '0;
    logic [FPG_DAT_W-1:0] rdat;
    logic                 ack;
    logic [3:0]           link    = 4'h0;
    logic [3:0]           ext_en  = 4'hF;
    logic [3:0]           ext_val = 4'h0;
    logic [3:0]           lvl, pin_o, pin_oe, pu, pd, cmp;
    logic                 thr;
    logic                 thr_exp = 1'b0;
    logic [4:0]           cfg [4];
    logic [4:0]           c;
    logic [1:0]           p;
    logic [31:0]          q;
    logic                 ce      = 1'b1;
    logic [4:0]           corner [6] = '{5'h00, 5'h1F, 5'h04, 5'h06, 5'h08, 5'h01};
    int                   fail_count  = 0;
    int                   check_count = 0;

    always #5 i_clk = ~i_clk;

    fpg_top i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_link_pull_low(link), .i_pin_i(lvl),
        .o_pin_o(pin_o), .o_pin_oe(pin_oe), .o_pull_up_en(pu), .o_pull_down_en(pd),
        .o_cmp_en(cmp), .o_threshold_sel(thr));

    fpg_pin_model i_pins (.i_pin_oe(pin_oe), .i_pin_o(pin_o), .i_pull_down_en(pd),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin_lvl(lvl));

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        @(posedge i_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= {24'h000000, d};
        do begin
            @(posedge i_clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    function automatic logic [8:0] cfg_adr(input logic [1:0] idx);
        return {FPG_IDX_PIN1_CONFIG + {5'h00, idx}, 2'b00};
    endfunction : cfg_adr

    // Expected {oe, pull-up, pull-down, comparator}
    function automatic logic [15:0] exp_pins();
        logic [3:0] oe, up, dn, cm;
        for (int i = 0; i < 4; i++) begin
            oe[i] = cfg[i][2] ? 1'b0 : (cfg[i][3] ? link[i] : cfg[i][0]);
            up[i] = cfg[i][2] & cfg[i][1];
            dn[i] = cfg[i][2] & ~cfg[i][1];
            cm[i] = cfg[i][4];
        end
        return {oe, up, dn, cm};
    endfunction : exp_pins

    function automatic logic [7:0] exp_rdb();
        logic [15:0] e;
        logic [3:0]  lv;
        e = exp_pins();
        for (int i = 0; i < 4; i++) begin
            lv[i] = e[12+i] ? 1'b0 : (ext_en[i] ? ext_val[i] : ~e[4+i]);
            lv[i] = lv[i] & cfg[i][4];
        end
        return {lv, 3'b000, thr_exp};
    endfunction : exp_rdb

    task automatic verify();
        repeat (3) @(posedge i_clk);
        #1;
        check(32'({pin_oe, pu, pd, cmp}), 32'(exp_pins()));
        check(32'(pin_o), 32'h00000000);
        check(32'(thr), 32'(thr_exp));
        wb(1'b0, {FPG_IDX_PIN_INPUT_READBACK, 2'b00}, 8'h00, 4'hF);
        check(q, {24'h000000, exp_rdb()});
    endtask : verify

    task automatic final_report();
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h1caa16e2));
        for (int i = 0; i < 4; i++) cfg[i] = 5'h18;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        verify();
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, cfg_adr(2'(i)), 8'h00, 4'hF);
            check(q, 32'h00000018);
        end
        $display("Test reset values done");
        for (int k = 0; k < 48; k++) begin
            p = 2'($urandom_range(3, 0));
            c = (k < 6) ? corner[k] : 5'($urandom);
            @(posedge i_clk);
            link    <= 4'($urandom);
            ext_en  <= 4'($urandom);
            ext_val <= 4'($urandom);
            cfg[p] = c;
            wb(1'b1, cfg_adr(p), {3'b000, c}, 4'h1);
            wb(1'b0, cfg_adr(p), 8'h00, 4'hF);
            check(q, {27'h0000000, c});
            verify();
        end
        $display("Test random configurations done");
        wb(1'b1, {FPG_IDX_PIN_INPUT_READBACK, 2'b00}, 8'hF1, 4'h1);
        thr_exp = 1'b1;
        verify();
        wb(1'b1, {FPG_IDX_PIN_INPUT_READBACK, 2'b00}, 8'h00, 4'h1);
        thr_exp = 1'b0;
        verify();
        $display("Test threshold and read-only levels done");
        wb(1'b1, cfg_adr(2'd0) | 9'h001, 8'h1F, 4'h1);
        wb(1'b1, cfg_adr(2'd1), {3'b000, ~cfg[1]}, 4'h0);
        wb(1'b0, {7'h5D, 2'b00}, 8'h00, 4'hF);
        check(q, 32'h00000000);
        for (int i = 0; i < 2; i++) begin
            wb(1'b0, cfg_adr(2'(i)), 8'h00, 4'hF);
            check(q, {27'h0000000, cfg[i]});
        end
        verify();
        $display("Test refused accesses done");
        wb(1'b1, {FPG_IDX_PIN_INPUT_READBACK, 2'b00}, 8'h01, 4'h1);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        link    <= 4'hF;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) cfg[i] = 5'h18;
        thr_exp = 1'b0;
        verify();
        wb(1'b0, cfg_adr(2'd2), 8'h00, 4'hF);
        check(q, 32'h00000018);
        $display("Test reset in mid-run done");
        q = 32'(exp_pins());
        @(posedge i_clk);
        ce   <= 1'b0;
        link <= 4'h0;
        repeat (3) @(posedge i_clk);
        #1;
        check(32'({pin_oe, pu, pd, cmp}), q);
        @(posedge i_clk);
        ce <= 1'b1;
        verify();
        $display("Test clock enable freeze done");
        final_report();
    end

    initial begin
        #200000;
        fail_count++;
        final_report();
    end
endmodule : tb_four_pin_gpio_config_port
